// file: hdl/dbfr_top.sv
// breakpoint match register, match logic and debug force-reset register
`timescale 1ns/1ps
`default_nettype none
module dbfr_top (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// debug status/control bits
	input wire logic breakpoint_enable,
	input wire logic force_or_tag_select,
	// breakpoint commands from the serial link
	input wire dbfr_pkg::dbfr_bkpt_req_s bkpt_req,
	output logic [15:0] bkpt_rdata,
	output logic bkpt_rvalid,
	// memory access port
	input wire dbfr_pkg::dbfr_mem_req_s mem_req,
	output logic [7:0] mem_rdata,
	output logic mem_hit,
	// cpu side
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_opcode_fetch,
	input wire logic cpu_insn_boundary,
	input wire logic cpu_exec_tagged,
	output logic opcode_tag,
	output logic force_bgnd,
	// system reset request
	output logic mcu_reset_req
);

	////////////////////////////////////////////////////////////////////////
	// decode

	function automatic logic frst_sel(input logic [15:0] a);
		frst_sel = (a == dbfr_pkg::FRST_ADDR);
	endfunction

	logic [15:0] bkpt_q, bkpt_d;
	logic [15:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [7:0] mrd_q, mrd_d;
	logic hit_q, hit_d;
	logic pend_q, pend_d;
	logic tag_q, tag_d;
	logic force_q, force_d;
	logic [2:0] rcnt_q, rcnt_d;
	logic match;

	// bkpt_q lives outside the memory map; only commands touch it
	always_comb begin
		bkpt_d = bkpt_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (bkpt_req.cmd == dbfr_pkg::DBFR_CMD_WR_BKPT) begin
			bkpt_d = bkpt_req.wdata;
		end
		if (bkpt_req.cmd == dbfr_pkg::DBFR_CMD_RD_BKPT) begin
			rdata_d = bkpt_q;
			rvalid_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// breakpoint match

	// disabled breakpoint ignores select bit and address entirely
	assign match = breakpoint_enable && (cpu_addr == bkpt_q);

	always_comb begin
		pend_d = pend_q;
		force_d = 1'b0;
		tag_d = 1'b0;
		if (!breakpoint_enable) begin
			pend_d = 1'b0;
		end else if (force_or_tag_select) begin
			// any address, need not be an opcode
			if (match) begin
				pend_d = 1'b1;
			end
			if ((pend_q || match) && cpu_insn_boundary) begin
				force_d = 1'b1;
				pend_d = 1'b0;
			end
		end else begin
			pend_d = 1'b0;
			tag_d = match && cpu_opcode_fetch;
			// the cpu queue reports when a tagged opcode reaches execution
			force_d = cpu_exec_tagged;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// force-reset register

	always_comb begin
		rcnt_d = rcnt_q;
		mrd_d = mrd_q;
		hit_d = 1'b0;
		if (rcnt_q != 3'h0) begin
			rcnt_d = rcnt_q - 3'h1;
		end
		if (frst_sel(mem_req.addr) && (mem_req.rd || mem_req.wr)) begin
			hit_d = 1'b1;
			mrd_d = dbfr_pkg::FRST_READ_VAL;
		end
		// user-program writes never reach the bit; zero writes do nothing
		if (frst_sel(mem_req.addr) && mem_req.wr && mem_req.from_debug
			&& mem_req.wdata[dbfr_pkg::FRST_BIT_POS]) begin
			rcnt_d = 3'(dbfr_pkg::RST_PULSE_CYC);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bkpt_q <= dbfr_pkg::BKPT_RESET_VAL;
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			mrd_q <= 8'h00;
			hit_q <= 1'b0;
			pend_q <= 1'b0;
			tag_q <= 1'b0;
			force_q <= 1'b0;
			rcnt_q <= 3'h0;
		end else if (clk_en) begin
			bkpt_q <= bkpt_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			mrd_q <= mrd_d;
			hit_q <= hit_d;
			pend_q <= pend_d;
			tag_q <= tag_d;
			force_q <= force_d;
			rcnt_q <= rcnt_d;
		end
	end

	assign bkpt_rdata = rdata_q;
	assign bkpt_rvalid = rvalid_q;
	assign mem_rdata = mrd_q;
	assign mem_hit = hit_q;
	assign opcode_tag = tag_q;
	assign force_bgnd = force_q;
	assign mcu_reset_req = (rcnt_q != 3'h0);

endmodule
`default_nettype wire

// file: hdl/dbfr_pkg.sv
// package: constants and carrier types for the debug breakpoint and force-reset block
package dbfr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// debug status/control field positions
	localparam int BREAKPOINT_ENABLE_POS = 5;
	localparam int FTS_POS = 4;
	// force-reset register layout
	localparam int FRST_BIT_POS = 0;
	localparam logic [7:0] FRST_READ_VAL = 8'h00;
	localparam logic [15:0] BKPT_RESET_VAL = 16'h0000;
	// memory-map byte address of the force-reset register (plain default)
	localparam logic [15:0] FRST_ADDR = 16'h1800;
	// cycles the device reset request is held
	localparam int RST_PULSE_CYC = 4;

	// serial debug command decoded by the link layer
	typedef enum logic [1:0] {
		DBFR_CMD_NONE,
		DBFR_CMD_RD_BKPT,
		DBFR_CMD_WR_BKPT
	} dbfr_cmd_e;

	typedef struct packed {
		dbfr_cmd_e cmd;
		logic [15:0] wdata;
	} dbfr_bkpt_req_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic from_debug;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dbfr_mem_req_s;
endpackage

// file: verif/dbfr_chk_assertions.sv
// checker: port properties of the breakpoint and force-reset block
`timescale 1ns/1ps
`default_nettype none
module dbfr_chk (
	input wire logic ref_clk, sys_rst, clk_en, breakpoint_enable, mem_hit,
	input wire logic bkpt_rvalid, opcode_tag, force_bgnd, mcu_reset_req,
	input wire dbfr_pkg::dbfr_bkpt_req_s bkpt_req,
	input wire dbfr_pkg::dbfr_mem_req_s mem_req,
	input wire logic [15:0] bkpt_rdata,
	input wire logic [7:0] mem_rdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire logic hit = clk_en && mem_req.addr == dbfr_pkg::FRST_ADDR &&
		(mem_req.wr || mem_req.rd);
	wire logic go = hit && mem_req.wr && mem_req.from_debug &&
		mem_req.wdata[0];
	wire logic rd = bkpt_req.cmd == dbfr_pkg::DBFR_CMD_RD_BKPT;
	chk_hit_addr: assert property (hit |=> mem_hit) else $error("hit");
	chk_zero_read: assert property (mem_hit |-> !mem_rdata)
		else $error("read");
	chk_reset_go: assert property (go |=> mcu_reset_req)
		else $error("start");
	chk_reset_src: assert property (
		$rose(mcu_reset_req) |-> $past(go)) else $error("source");
	chk_reset_len: assert property (
		$rose(mcu_reset_req) |-> mcu_reset_req[*4] ##1 !mcu_reset_req)
		else $error("length");
	chk_bkpt_rd: assert property (rd |=> bkpt_rvalid) else $error("valid");
	chk_bkpt_wr: assert property (
		bkpt_req.cmd == dbfr_pkg::DBFR_CMD_WR_BKPT ##1 rd |=>
		bkpt_rdata == $past(bkpt_req.wdata, 2)) else $error("readback");
	chk_bkpt_off: assert property (
		!breakpoint_enable [*2] |-> !opcode_tag && !force_bgnd)
		else $error("off");
	cover property ($rose(mcu_reset_req));
	cover property (opcode_tag);
	cover property (force_bgnd);
endmodule
bind dbfr_top dbfr_chk i_chk (.*);
`default_nettype wire

// file: verif/dbfr_host.sv
// debug host model: breakpoint commands and force-reset memory requests
`timescale 1ns/1ps
`default_nettype none
module dbfr_host (
	input wire logic ref_clk,
	output var dbfr_pkg::dbfr_bkpt_req_s bkpt_req = '0,
	output var dbfr_pkg::dbfr_mem_req_s mem_req = '0
);
	// one command per edge, so back-to-back loads need no idle gap
	task bk(input logic [17:0] v); @(posedge ref_clk) bkpt_req <= v; endtask
	// {wr, rd, debug, data}: the register is only reached as memory
	task mw(input logic [10:0] v);
		@(posedge ref_clk) mem_req <= {v[10:8], dbfr_pkg::FRST_ADDR, v[7:0]};
	endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// testbench: breakpoint load, match modes and debug force-reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
	logic ref_clk = 0, sys_rst = 1, clk_en = 1, bkpt_rvalid, mem_hit;
	logic opcode_tag, force_bgnd, mcu_reset_req;
	logic [4:0] c = 0;
	logic [15:0] ca = 0, a, bkpt_rdata;
	logic [10:0] f;
	logic [7:0] mem_rdata;
	dbfr_pkg::dbfr_bkpt_req_s bkpt_req;
	dbfr_pkg::dbfr_mem_req_s mem_req;
	int fails = 0, tests_run = 0;
	always #2.5 ref_clk = ~ref_clk;
	dbfr_host i_host (.*);
	dbfr_top i_dut (.*, .cpu_addr(ca), .breakpoint_enable(c[4]),
		.force_or_tag_select(c[3]), .cpu_opcode_fetch(c[2]),
		.cpu_insn_boundary(c[1]), .cpu_exec_tagged(c[0]));
	function automatic logic fires(input logic [10:0] v);
		return v[10] & v[8] & v[0];
	endfunction
	task results;
		$display("fails %0d of %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// {enable, select, fetch, boundary, exec} for one edge on address a
	task cpu(input logic [4:0] v);
		@(posedge ref_clk) {ca, c} <= {a, v};
		@(posedge ref_clk) {ca, c[2:0]} <= {~a, 3'h0};
		#1;
	endtask
	initial begin
		#5000 fails++;
		results;
	end
	initial begin
		void'($urandom(32'hee0e1805));
		repeat (2) @(posedge ref_clk);
		sys_rst <= 0;
		repeat (5) begin
			a = 16'($urandom);
			i_host.bk({dbfr_pkg::DBFR_CMD_WR_BKPT, a});
			i_host.bk({dbfr_pkg::DBFR_CMD_RD_BKPT, ~a});
			i_host.bk({dbfr_pkg::DBFR_CMD_NONE, ~a});
			#1 `CHK({bkpt_rvalid, bkpt_rdata}, {1'b1, a})
			for (int m = 0; m < 3; m++) begin
				cpu({m != 0, m == 2, 3'h6});
				`CHK({opcode_tag, force_bgnd}, {m == 1, m == 2})
				cpu({m != 0, m == 2, 3'h1});
				`CHK(force_bgnd, m == 1)
			end
		end
		for (int k = 0; k < 16; k++) begin
			f = {k[3:1], 7'($urandom), k[0]};
			i_host.mw(f);
			i_host.mw(11'h0);
			#1;
			`CHK({mem_hit, mem_rdata, mcu_reset_req},
				{|k[3:2], 8'h00, fires(f)})
			repeat (4) @(posedge ref_clk);
		end
		// a firing write while the enable is low must leave all state frozen
		@(posedge ref_clk) clk_en <= 0;
		i_host.mw(11'h501);
		i_host.mw(11'h0);
		#1 `CHK({mem_hit, mcu_reset_req}, 2'b00)
		@(posedge ref_clk) clk_en <= 1;
		results;
	end
endmodule
`default_nettype wire
